// >>> verilog/hp_pkg.sv
// shared constants and types of the host mailbox port
package hp_pkg;
   localparam int DATA_W = 16;
   localparam int BYTE_W = 8;
   localparam int NUM_DATA = 6;
   localparam int HOST_AW = 3;
   localparam int CORE_AW = 4;
   // host-side register indices
   localparam logic [2:0] HOST_IDX_STAT_HW = 3'h6;
   localparam logic [2:0] HOST_IDX_STAT_CW = 3'h7;
   // core-side register indices (0..5 are the mailbox data registers)
   localparam logic [3:0] CORE_IDX_STAT_HW = 4'h6;
   localparam logic [3:0] CORE_IDX_STAT_CW = 4'h7;
   localparam logic [3:0] CORE_IDX_MBOX_MASK = 4'h8;
   localparam logic [3:0] CORE_IDX_IRQ_STAT = 4'h9;
   localparam logic [3:0] CORE_IDX_IRQ_MASK = 4'ha;
   localparam logic [3:0] CORE_IDX_CONFIG = 4'hb;
   // mailbox mask layout: write enables low, read enables high
   localparam int MASK_WR_LSB = 0;
   localparam int MASK_RD_LSB = 8;
   localparam logic [15:0] MASK_RESET = 16'h0000;
   // host status register 7: soft reset request bit
   localparam int SRST_BIT = 7;
   // interrupt status layout
   localparam int IRQ_W = 3;
   localparam int IRQ_HOST_WROTE = 0;
   localparam int IRQ_HOST_READ = 1;
   localparam int IRQ_SOFT_RESET = 2;
   localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
   // core interrupt vectors of the two requests
   localparam logic [15:0] VEC_HOST_WRITE = 16'h0008;
   localparam logic [15:0] VEC_HOST_READ = 16'h000c;
   // soft reset pulse length in processor cycles
   localparam logic [2:0] SOFT_RESET_CYCLES = 3'h5;
   // strobe idle levels after reset: select, read/dir, write/ds
   localparam logic [2:0] STROBE_IDLE = 3'h7;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_CAPTURE = 2'b01,
      ST_LOAD = 2'b11,
      ST_ACK = 2'b10
   } hp_state_t;
endpackage

// >>> verilog/hp_mem_if.sv
// interface between the port control and the mailbox storage
`timescale 1ns/1ps
interface hp_mem_if;
   logic host_we;
   logic [2:0] host_wa;
   logic [15:0] host_wd;
   logic [2:0] host_ra;
   logic [15:0] host_rd;
   logic core_we;
   logic [2:0] core_wa;
   logic [15:0] core_wd;
   logic [2:0] core_ra;
   logic [15:0] core_rd;
   modport ctrl (output host_we, host_wa, host_wd, host_ra, core_we, core_wa, core_wd, core_ra,
                 input host_rd, core_rd);
   modport mem (input host_we, host_wa, host_wd, host_ra, core_we, core_wa, core_wd, core_ra,
                output host_rd, core_rd);
endinterface

// >>> verilog/hp_sync.sv
// two-flop synchroniser for a group of asynchronous levels
`timescale 1ns/1ps
module hp_sync #(
   parameter int W = 3,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } hp_sync_st_t;
   hp_sync_st_t r_q, r_d;

   always_comb begin
      r_d = r_q;
      r_d.s1 = async_i;
      r_d.s2 = r_q.s1;
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         r_q <= {RST_VAL, RST_VAL};
      end else begin
         r_q <= r_d;
      end
   end

   assign sync_o = r_q.s2;
endmodule // hp_sync

// >>> verilog/hp_mbox_mem.sv
// six mailbox words, host and core ports, registered reads
`timescale 1ns/1ps
module hp_mbox_mem (
   input wire logic clk_i,
   input wire logic arst_n_i,
   hp_mem_if.mem mif
);
   import hp_pkg::*;
   typedef struct packed {
      logic [NUM_DATA-1:0][DATA_W-1:0] word;
      logic [DATA_W-1:0] host_rd;
      logic [DATA_W-1:0] core_rd;
   } hp_mem_st_t;
   hp_mem_st_t r_q, r_d;

   always_comb begin
      r_d = r_q;
      // indices past the last word read as zero
      r_d.host_rd = (mif.host_ra < 3'(NUM_DATA)) ? r_q.word[mif.host_ra] : '0;
      r_d.core_rd = (mif.core_ra < 3'(NUM_DATA)) ? r_q.word[mif.core_ra] : '0;
      for (int i = 0; i < NUM_DATA; i++) begin
         // host wins a same-cycle collision on one word
         if (mif.host_we && (mif.host_wa == 3'(i))) begin
            r_d.word[i] = mif.host_wd;
         end else if (mif.core_we && (mif.core_wa == 3'(i))) begin
            r_d.word[i] = mif.core_wd;
         end
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         r_q <= '0;
      end else begin
         r_q <= r_d;
      end
   end

   assign mif.host_rd = r_q.host_rd;
   assign mif.core_rd = r_q.core_rd;
endmodule // hp_mbox_mem

// >>> verilog/hp_host_port.sv
// host parallel mailbox port: host pin protocol, mailbox flags, core registers
`timescale 1ns/1ps
// Behaviour
// - width-select strap low gives 16-bit host transfers, high gives 8-bit.
// - with memory map select low, boot-source strap chooses memory or host boot.
// - strobe-style strap low: separate read/write; high: direction plus data strobe.
// - bus strap low: 3-bit address plus data bus; high: multiplexed with latch.
// - upper address pin is address bit 2, or latch enable when multiplexed.
// - bus pins carry data, or address in latch phase when multiplexed.
// - 8-bit reads drive only the low byte, upper byte stays undriven.
// - 8-bit host writes store zeros in the upper byte.
// - six data registers, two status registers, per-register interrupt mask.
// - core reaches all data registers through its data-memory accesses.
// - status kept current for interrupt or polling use.
// - host side asynchronous; strobes synchronised, core keeps running.
// - host soft reset request gives exactly five cycles of reset.
// - host boot selection is reported on BOOT_FROM_HOST_O and in the core config register.
// - separate host-write and host-read interrupt requests to the core.
module hp_host_port (
   input wire logic CLK_I,
   input wire logic ARST_N_I,
   input wire logic HOST_BYTE_MODE_I,
   input wire logic MEMORY_MAP_SELECT_I,
   input wire logic BOOT_SOURCE_SELECT_I,
   input wire logic STROBE_STYLE_SELECT_I,
   input wire logic BUS_ARRANGEMENT_SELECT_I,
   input wire logic HOST_PORT_SEL_N_I,
   input wire logic HOST_READ_OR_DIRECTION_I,
   input wire logic HOST_WRITE_OR_DATA_STROBE_I,
   input wire logic HOST_ADDR2_OR_LATCH_ENABLE_I,
   input wire logic [1:0] HOST_ADDR_LOW_I,
   input wire logic [hp_pkg::DATA_W-1:0] HOST_BUS_PINS_I,
   output logic [hp_pkg::DATA_W-1:0] HOST_BUS_PINS_O,
   output logic [hp_pkg::DATA_W-1:0] HOST_BUS_PINS_OE_N_O,
   output logic HOST_PORT_ACK_O,
   input wire logic [hp_pkg::CORE_AW-1:0] CORE_ADDR_I,
   input wire logic [hp_pkg::DATA_W-1:0] CORE_WDATA_I,
   input wire logic CORE_WR_I,
   input wire logic CORE_RD_I,
   output logic [hp_pkg::DATA_W-1:0] CORE_RDATA_O,
   output logic HOST_WRITE_IRQ_O,
   output logic HOST_READ_IRQ_O,
   output logic IRQ_O,
   output logic SOFT_RESET_O,
   output logic BOOT_FROM_HOST_O
);
   import hp_pkg::*;

   typedef struct packed {
      hp_state_t state;
      logic is_read;
      logic [HOST_AW-1:0] addr;
      logic [HOST_AW-1:0] ale_addr;
      logic [DATA_W-1:0] wdata;
      logic byte_mode;
      logic [DATA_W-1:0] bus_out;
      logic drive;
      logic [NUM_DATA-1:0] host_wr;
      logic [NUM_DATA-1:0] core_wr;
      logic [NUM_DATA-1:0] rd_done;
      logic [DATA_W-1:0] mbox_mask;
      logic [IRQ_W-1:0] irq_stat;
      logic [IRQ_W-1:0] irq_mask;
      logic [2:0] srst_cnt;
      logic [DATA_W-1:0] core_rdata;
      logic core_from_mem;
      logic boot_host;
   } hp_top_st_t;

   hp_top_st_t r_q, r_d;
   hp_mem_if mif ();
   logic [2:0] strobe_s;
   logic sel_n_s;
   logic pin_a_s;
   logic pin_b_s;
   logic req_rd;
   logic req_wr;
   logic [HOST_AW-1:0] pin_addr;
   logic [NUM_DATA-1:0] hw_set, hw_clr, cw_set, cw_clr, rd_set, rd_clr;
   logic [IRQ_W-1:0] irq_set;
   logic irq_clr;

   // data register index test, used on both sides
   function automatic logic hp_is_data(input logic [CORE_AW-1:0] a);
      hp_is_data = (a < CORE_AW'(NUM_DATA));
   endfunction

   // one-hot flag vector for a data register index
   function automatic logic [NUM_DATA-1:0] hp_onehot(input logic [CORE_AW-1:0] a,
                                                     input logic en);
      hp_onehot = '0;
      for (int i = 0; i < NUM_DATA; i++) begin
         if (en && (a == CORE_AW'(i))) begin
            hp_onehot[i] = 1'b1;
         end
      end
   endfunction

   hp_sync #(.W(3), .RST_VAL(STROBE_IDLE)) u_sync (
      .clk_i(CLK_I),
      .arst_n_i(ARST_N_I),
      .async_i({HOST_PORT_SEL_N_I, HOST_READ_OR_DIRECTION_I, HOST_WRITE_OR_DATA_STROBE_I}),
      .sync_o(strobe_s)
   );

   hp_mbox_mem u_mem (
      .clk_i(CLK_I),
      .arst_n_i(ARST_N_I),
      .mif(mif.mem)
   );

   assign sel_n_s = strobe_s[2];
   assign pin_a_s = strobe_s[1];
   assign pin_b_s = strobe_s[0];

   // pin roles follow the strobe style strap
   always_comb begin
      if (STROBE_STYLE_SELECT_I) begin
         req_rd = !sel_n_s && !pin_b_s && pin_a_s;
         req_wr = !sel_n_s && !pin_b_s && !pin_a_s;
      end else begin
         req_rd = !sel_n_s && !pin_a_s;
         req_wr = !sel_n_s && !pin_b_s;
      end
   end

   // register address from pins or from the latched address phase
   always_comb begin
      if (BUS_ARRANGEMENT_SELECT_I) begin
         pin_addr = r_q.ale_addr;
      end else begin
         pin_addr = {HOST_ADDR2_OR_LATCH_ENABLE_I, HOST_ADDR_LOW_I};
      end
   end

   always_comb begin
      r_d = r_q;
      hw_set = '0;
      hw_clr = '0;
      cw_set = '0;
      cw_clr = '0;
      rd_set = '0;
      rd_clr = '0;
      irq_set = '0;
      irq_clr = 1'b0;
      mif.host_we = 1'b0;
      mif.host_wa = r_q.addr;
      mif.host_wd = r_q.wdata;
      mif.host_ra = r_q.addr;
      mif.core_we = 1'b0;
      mif.core_wa = CORE_ADDR_I[HOST_AW-1:0];
      mif.core_wd = CORE_WDATA_I;
      mif.core_ra = CORE_ADDR_I[HOST_AW-1:0];

      r_d.boot_host = !MEMORY_MAP_SELECT_I && BOOT_SOURCE_SELECT_I;

      // address phase of the multiplexed bus
      if (BUS_ARRANGEMENT_SELECT_I && HOST_ADDR2_OR_LATCH_ENABLE_I) begin
         r_d.ale_addr = HOST_BUS_PINS_I[HOST_AW-1:0];
      end

      if (r_q.srst_cnt != 3'h0) begin
         r_d.srst_cnt = r_q.srst_cnt - 3'h1;
      end

      // host access sequence
      case (r_q.state)
         ST_IDLE: begin
            r_d.drive = 1'b0;
            if (req_rd || req_wr) begin
               r_d.is_read = req_rd;
               r_d.addr = pin_addr;
               r_d.byte_mode = HOST_BYTE_MODE_I;
               if (HOST_BYTE_MODE_I) begin
                  r_d.wdata = {8'h00, HOST_BUS_PINS_I[BYTE_W-1:0]};
               end else begin
                  r_d.wdata = HOST_BUS_PINS_I;
               end
               r_d.state = ST_CAPTURE;
            end
         end
         ST_CAPTURE: begin
            if (r_q.is_read) begin
               if (hp_is_data({1'b0, r_q.addr})) begin
                  cw_clr = hp_onehot({1'b0, r_q.addr}, 1'b1);
                  rd_set = hp_onehot({1'b0, r_q.addr}, 1'b1);
                  irq_set[IRQ_HOST_READ] = 1'b1;
               end
            end else begin
               if (hp_is_data({1'b0, r_q.addr})) begin
                  mif.host_we = 1'b1;
                  hw_set = hp_onehot({1'b0, r_q.addr}, 1'b1);
                  irq_set[IRQ_HOST_WROTE] = 1'b1;
               end else if (r_q.addr == HOST_IDX_STAT_CW && r_q.wdata[SRST_BIT]
                            && r_q.srst_cnt == 3'h0) begin
                  r_d.srst_cnt = SOFT_RESET_CYCLES;
                  irq_set[IRQ_SOFT_RESET] = 1'b1;
               end
            end
            r_d.state = ST_LOAD;
         end
         ST_LOAD: begin
            if (r_q.is_read) begin
               if (r_q.addr == HOST_IDX_STAT_HW) begin
                  r_d.bus_out = {10'h000, r_q.host_wr};
               end else if (r_q.addr == HOST_IDX_STAT_CW) begin
                  r_d.bus_out = {10'h000, r_q.core_wr};
               end else begin
                  r_d.bus_out = mif.host_rd;
               end
               if (r_q.byte_mode) begin
                  r_d.bus_out[DATA_W-1:BYTE_W] = 8'h00;
               end
               r_d.drive = 1'b1;
            end
            r_d.state = ST_ACK;
         end
         ST_ACK: begin
            if (!(req_rd || req_wr)) begin
               r_d.drive = 1'b0;
               r_d.state = ST_IDLE;
            end
         end
         default: begin
            r_d.drive = 1'b0;
            r_d.state = ST_IDLE;
         end
      endcase

      // core register port
      r_d.core_from_mem = 1'b0;
      if (CORE_WR_I) begin
         if (hp_is_data(CORE_ADDR_I)) begin
            mif.core_we = 1'b1;
            cw_set = hp_onehot(CORE_ADDR_I, 1'b1);
            rd_clr = hp_onehot(CORE_ADDR_I, 1'b1);
         end else if (CORE_ADDR_I == CORE_IDX_MBOX_MASK) begin
            r_d.mbox_mask = CORE_WDATA_I;
         end else if (CORE_ADDR_I == CORE_IDX_IRQ_MASK) begin
            r_d.irq_mask = CORE_WDATA_I[IRQ_W-1:0];
         end
      end
      if (CORE_RD_I) begin
         r_d.core_rdata = '0;
         if (hp_is_data(CORE_ADDR_I)) begin
            r_d.core_from_mem = 1'b1;
            hw_clr = hp_onehot(CORE_ADDR_I, 1'b1);
         end else begin
            case (CORE_ADDR_I)
               CORE_IDX_STAT_HW: r_d.core_rdata = {10'h000, r_q.host_wr};
               CORE_IDX_STAT_CW: r_d.core_rdata = {10'h000, r_q.core_wr};
               CORE_IDX_MBOX_MASK: r_d.core_rdata = r_q.mbox_mask;
               CORE_IDX_IRQ_STAT: begin
                  r_d.core_rdata = {13'h0000, r_q.irq_stat};
                  irq_clr = 1'b1;
               end
               CORE_IDX_IRQ_MASK: r_d.core_rdata = {13'h0000, r_q.irq_mask};
               CORE_IDX_CONFIG: begin
                  r_d.core_rdata = {12'h000, r_q.boot_host, BUS_ARRANGEMENT_SELECT_I,
                                    STROBE_STYLE_SELECT_I, HOST_BYTE_MODE_I};
               end
               default: r_d.core_rdata = '0;
            endcase
         end
      end

      // flag updates, a set beats a clear in the same cycle
      r_d.host_wr = (r_q.host_wr & ~hw_clr) | hw_set;
      r_d.core_wr = (r_q.core_wr & ~cw_clr) | cw_set;
      r_d.rd_done = (r_q.rd_done & ~rd_clr) | rd_set;
      r_d.irq_stat = (irq_clr ? '0 : r_q.irq_stat) | irq_set;
   end

   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         r_q <= '0;
         r_q.state <= ST_IDLE;
         r_q.mbox_mask <= MASK_RESET;
         r_q.irq_mask <= IRQ_MASK_RESET;
      end else begin
         r_q <= r_d;
      end
   end

   assign HOST_BUS_PINS_O = r_q.bus_out;
   // upper byte stays undriven on byte-wide reads
   assign HOST_BUS_PINS_OE_N_O = !r_q.drive ? 16'hffff :
                                 (r_q.byte_mode ? 16'hff00 : 16'h0000);
   assign HOST_PORT_ACK_O = (r_q.state == ST_ACK);
   assign CORE_RDATA_O = r_q.core_from_mem ? mif.core_rd : r_q.core_rdata;
   assign HOST_WRITE_IRQ_O = |(r_q.host_wr & r_q.mbox_mask[MASK_WR_LSB +: NUM_DATA]);
   assign HOST_READ_IRQ_O = |(r_q.rd_done & r_q.mbox_mask[MASK_RD_LSB +: NUM_DATA]);
   assign IRQ_O = |(r_q.irq_stat & r_q.irq_mask);
   assign SOFT_RESET_O = (r_q.srst_cnt != 3'h0);
   assign BOOT_FROM_HOST_O = r_q.boot_host;
endmodule // hp_host_port

// >>> tb/hp_host_port_sva.sv
// assertion checker for the host mailbox port
`timescale 1ns/1ps
module hp_host_port_sva (
   input wire logic CLK_I,
   input wire logic ARST_N_I,
   input wire logic HOST_BYTE_MODE_I,
   input wire logic MEMORY_MAP_SELECT_I,
   input wire logic BOOT_SOURCE_SELECT_I,
   input wire logic HOST_PORT_SEL_N_I,
   input wire logic [hp_pkg::DATA_W-1:0] HOST_BUS_PINS_OE_N_O,
   input wire logic HOST_PORT_ACK_O,
   input wire logic [hp_pkg::CORE_AW-1:0] CORE_ADDR_I,
   input wire logic CORE_WR_I,
   input wire logic CORE_RD_I,
   input wire logic [hp_pkg::DATA_W-1:0] CORE_RDATA_O,
   input wire logic HOST_WRITE_IRQ_O,
   input wire logic HOST_READ_IRQ_O,
   input wire logic SOFT_RESET_O,
   input wire logic BOOT_FROM_HOST_O
);
   import hp_pkg::*;
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!ARST_N_I);
   soft_rst_len_a: assert property ($rose(SOFT_RESET_O) |-> SOFT_RESET_O [*5] ##1 !SOFT_RESET_O)
      else $error("soft reset pulse has wrong length");
   byte_upper_a: assert property (HOST_BYTE_MODE_I && $past(HOST_BYTE_MODE_I)
      |-> HOST_BUS_PINS_OE_N_O[15:8] == 8'hff) else $error("upper byte driven in byte mode");
   drive_ack_a: assert property (!HOST_PORT_ACK_O |-> HOST_BUS_PINS_OE_N_O == 16'hffff)
      else $error("bus driven without acknowledge");
   ack_drop_a: assert property ($rose(HOST_PORT_SEL_N_I) |-> ##[1:4] !HOST_PORT_ACK_O)
      else $error("acknowledge held after deselect");
   ack_cause_a: assert property ($rose(HOST_PORT_ACK_O) |-> $past(HOST_PORT_SEL_N_I, 3) == 1'b0)
      else $error("acknowledge without select");
   wr_irq_rise_a: assert property ($rose(HOST_WRITE_IRQ_O) |-> !HOST_PORT_SEL_N_I || $past(CORE_WR_I))
      else $error("write request without cause");
   rd_irq_rise_a: assert property ($rose(HOST_READ_IRQ_O) |-> !HOST_PORT_SEL_N_I || $past(CORE_WR_I))
      else $error("read request without cause");
   wr_irq_fall_a: assert property ($fell(HOST_WRITE_IRQ_O) |-> $past(CORE_RD_I) || $past(CORE_WR_I))
      else $error("write request dropped without core access");
   unmapped_rd_a: assert property (CORE_RD_I && CORE_ADDR_I[3:2] == 2'b11 |=> CORE_RDATA_O == 16'h0000)
      else $error("unmapped read not zero");
   boot_sel_a: assert property (BOOT_FROM_HOST_O == $past(!MEMORY_MAP_SELECT_I && BOOT_SOURCE_SELECT_I))
      else $error("boot source wrong");
   cover property ($rose(SOFT_RESET_O));
   cover property ($rose(HOST_PORT_ACK_O) && HOST_BYTE_MODE_I);
   cover property ($rose(HOST_WRITE_IRQ_O));
endmodule // hp_host_port_sva
bind hp_host_port hp_host_port_sva chk_u (.CLK_I, .ARST_N_I, .HOST_BYTE_MODE_I, .MEMORY_MAP_SELECT_I,
   .BOOT_SOURCE_SELECT_I, .HOST_PORT_SEL_N_I, .HOST_BUS_PINS_OE_N_O, .HOST_PORT_ACK_O, .CORE_ADDR_I,
   .CORE_WR_I, .CORE_RD_I, .CORE_RDATA_O, .HOST_WRITE_IRQ_O, .HOST_READ_IRQ_O, .SOFT_RESET_O,
   .BOOT_FROM_HOST_O);

// >>> tb/hp_host_model.sv
// host processor model driving the parallel mailbox pins
`timescale 1ns/1ps
module hp_host_model (
   input wire logic clk_i,
   input wire logic style_i,
   input wire logic mux_i,
   input wire logic ack_i,
   input wire logic [15:0] dev_i,
   input wire logic [15:0] oe_n_i,
   output logic sel_n_o,
   output logic rdd_o,
   output logic wrds_o,
   output logic a2ale_o,
   output logic [1:0] alow_o,
   output wire logic [15:0] bus_o
);
   logic [15:0] drv_q;
   // released pins show the inverse of the last host value
   assign bus_o = (dev_i & ~oe_n_i) | (drv_q & oe_n_i);
   initial begin
      sel_n_o = 1'b1;
      rdd_o = 1'b1;
      wrds_o = 1'b1;
      a2ale_o = 1'b0;
      alow_o = 2'h0;
      drv_q = 16'h0000;
   end
   task automatic xfer(input logic rd, input logic [2:0] a, input logic [15:0] d, input int hold,
                       output logic [15:0] q, output logic ok);
      int n;
      @(posedge clk_i);
      if (mux_i) begin
         drv_q <= {13'h0, a};
         a2ale_o <= 1'b1;
         @(posedge clk_i);
         a2ale_o <= 1'b0;
      end else begin
         a2ale_o <= a[2];
         alow_o <= a[1:0];
      end
      sel_n_o <= 1'b0;
      drv_q <= rd ? ~drv_q : d;
      rdd_o <= style_i ? rd : !rd;
      wrds_o <= style_i ? 1'b0 : rd;
      ok = 1'b0;
      for (n = 0; n < 40 && !ok; n++) begin
         @(posedge clk_i);
         ok = ack_i;
      end
      q = bus_o;
      repeat (hold) @(posedge clk_i);
      sel_n_o <= 1'b1;
      rdd_o <= 1'b1;
      wrds_o <= 1'b1;
      drv_q <= ~drv_q;
      for (n = 0; n < 10 && ack_i; n++) @(posedge clk_i);
      if (ack_i) ok = 1'b0;
   endtask
endmodule // hp_host_model

// >>> tb/hp_host_port_tb.sv
// self-checking testbench of the host mailbox port
`timescale 1ns/1ps
module hp_host_port_tb;
   logic clk, arst_n, byte_m, memory_map_select, boot, style, mux, core_wr, core_rd;
   logic [3:0] core_addr;
   logic [15:0] core_wd;
   wire logic sel_n, rdd, wrds, a2ale, ack, wirq, rirq, irq, srst, bfh;
   wire logic [1:0] alow;
   wire logic [15:0] bus_i, bus_o, oe_n, core_rd_o;
   int fail_count = 0;
   int tests_run = 0;
   hp_host_port dut_u (.CLK_I(clk), .ARST_N_I(arst_n), .HOST_BYTE_MODE_I(byte_m),
      .MEMORY_MAP_SELECT_I(memory_map_select), .BOOT_SOURCE_SELECT_I(boot), .STROBE_STYLE_SELECT_I(style),
      .BUS_ARRANGEMENT_SELECT_I(mux), .HOST_PORT_SEL_N_I(sel_n), .HOST_READ_OR_DIRECTION_I(rdd),
      .HOST_WRITE_OR_DATA_STROBE_I(wrds), .HOST_ADDR2_OR_LATCH_ENABLE_I(a2ale),
      .HOST_ADDR_LOW_I(alow), .HOST_BUS_PINS_I(bus_i), .HOST_BUS_PINS_O(bus_o),
      .HOST_BUS_PINS_OE_N_O(oe_n), .HOST_PORT_ACK_O(ack), .CORE_ADDR_I(core_addr),
      .CORE_WDATA_I(core_wd), .CORE_WR_I(core_wr), .CORE_RD_I(core_rd), .CORE_RDATA_O(core_rd_o),
      .HOST_WRITE_IRQ_O(wirq), .HOST_READ_IRQ_O(rirq), .IRQ_O(irq), .SOFT_RESET_O(srst),
      .BOOT_FROM_HOST_O(bfh));
   hp_host_model hm_u (.clk_i(clk), .style_i(style), .mux_i(mux), .ack_i(ack), .dev_i(bus_o),
      .oe_n_i(oe_n), .sel_n_o(sel_n), .rdd_o(rdd), .wrds_o(wrds), .a2ale_o(a2ale),
      .alow_o(alow), .bus_o(bus_i));
   task automatic report_and_stop();
      $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cwr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      core_addr <= a;
      core_wd <= d;
      core_wr <= 1'b1;
      @(posedge clk);
      core_wr <= 1'b0;
   endtask
   task automatic crd(input logic [3:0] a, output logic [15:0] q);
      @(posedge clk);
      core_addr <= a;
      core_rd <= 1'b1;
      @(posedge clk);
      core_rd <= 1'b0;
      @(posedge clk);
      q = core_rd_o;
   endtask
   task automatic hx(input logic rd, input logic [2:0] a, input logic [15:0] d, input int hold,
                     output logic [15:0] q);
      logic ok;
      hm_u.xfer(rd, a, d, hold, q, ok);
      chk({15'h0, ok}, 16'h0001);
      if (ok !== 1'b1) report_and_stop();
   endtask
   task automatic t_boot();
      logic [15:0] q;
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         {memory_map_select, boot} <= i[1:0];
         repeat (2) @(posedge clk);
         chk({15'h0, bfh}, {15'h0, !i[1] && i[0]});
      end
      @(posedge clk);
      {memory_map_select, boot} <= 2'b01;
      crd(4'hb, q);
      chk(q, 16'h0008);
      $display("strap test done");
   endtask
   task automatic t_host_wr();
      logic [15:0] q;
      cwr(4'h8, 16'h3f3f);
      cwr(4'ha, 16'h0007);
      hx(1'b0, 3'h2, 16'h1234, 0, q);
      chk({15'h0, wirq}, 16'h0001);
      chk({15'h0, irq}, 16'h0001);
      crd(4'h6, q);
      chk(q, 16'h0004);
      crd(4'h9, q);
      chk(q, 16'h0001);
      chk({15'h0, irq}, 16'h0000);
      crd(4'h2, q);
      chk(q, 16'h1234);
      crd(4'h6, q);
      chk(q, 16'h0000);
      chk({15'h0, wirq}, 16'h0000);
      crd(4'hc, q);
      chk(q, 16'h0000);
      $display("host write test done");
   endtask
   task automatic t_mux();
      logic [15:0] q;
      @(posedge clk);
      style <= 1'b1;
      mux <= 1'b1;
      cwr(4'h5, 16'h5aa5);
      hx(1'b1, 3'h7, 16'h0000, 3, q);
      chk({10'h0, q[5:0]}, 16'h0020);
      hx(1'b1, 3'h5, 16'h0000, 0, q);
      chk(q, 16'h5aa5);
      chk({15'h0, rirq}, 16'h0001);
      crd(4'h7, q);
      chk(q, 16'h0000);
      cwr(4'h5, 16'h0000);
      @(posedge clk);
      chk({15'h0, rirq}, 16'h0000);
      hx(1'b0, 3'h1, 16'hbeef, 0, q);
      crd(4'h1, q);
      chk(q, 16'hbeef);
      style <= 1'b0;
      mux <= 1'b0;
      $display("multiplexed test done");
   endtask
   task automatic t_byte();
      logic [15:0] q;
      @(posedge clk);
      byte_m <= 1'b1;
      hx(1'b0, 3'h3, 16'habcd, 0, q);
      crd(4'h3, q);
      chk(q, 16'h00cd);
      cwr(4'h4, 16'h9876);
      hx(1'b1, 3'h4, 16'h0000, 2, q);
      chk({8'h00, q[7:0]}, 16'h0076);
      byte_m <= 1'b0;
      $display("byte mode test done");
   endtask
   task automatic t_srst();
      logic [15:0] q;
      int n;
      crd(4'h9, q);
      n = 0;
      fork
         hx(1'b0, 3'h7, 16'h0080, 0, q);
         repeat (30) begin
            @(posedge clk);
            n += srst;
         end
      join
      chk(n[15:0], 16'h0005);
      crd(4'h9, q);
      chk(q, 16'h0004);
      $display("soft reset test done");
   endtask
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      arst_n = 1'b0;
      byte_m = 1'b0;
      memory_map_select = 1'b0;
      boot = 1'b0;
      style = 1'b0;
      mux = 1'b0;
      core_addr = 4'h0;
      core_wd = 16'h0000;
      core_wr = 1'b0;
      core_rd = 1'b0;
      repeat (5) @(posedge clk);
      arst_n <= 1'b1;
      t_boot();
      t_host_wr();
      t_mux();
      t_byte();
      t_srst();
      report_and_stop();
   end
endmodule // hp_host_port_tb
